// [hw/adcrd_top.sv]
// conversion sequencer and readout of a 16-bit successive-approximation converter
// assumes pins are asynchronous to i_clk; the code input comes from the
// comparator logic on i_clk and is stable at the end of conversion
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module adcrd_top
	import adcrd_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_convert_start_n,
	input wire logic i_fast_sel,
	input wire logic i_power_sel,
	input wire logic i_cs_n,
	input wire logic i_bus_req_n,
	input wire logic [15:0] i_conv_code,
	output logic o_busy,
	output logic [15:0] o_data,
	output logic o_data_oe_n,
	output logic o_frame_sync,
	output logic o_frame_sync_oe_n,
	output logic o_serial_clk,
	output logic o_serial_clk_oe_n,
	output logic o_serial_data_out,
	output logic o_serial_data_out_oe_n
);

	adcrd_ser_if ser_if ();

	logic [2:0] cnv_sync_r;
	logic [1:0] fast_sync_r, power_sync_r, cs_sync_r, req_sync_r;
	adcrd_state_t st_r;
	adcrd_mode_t mode_r;
	logic [7:0] cnt_r;
	logic busy_r;
	logic res_upd_r;
	logic valid_r;
	logic [15:0] result_r;
	logic ser_run_r;
	logic [2:0] ctrl_r;
	logic data_oe_n_r;
	logic ser_oe_n_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic cnv_fall;
	logic apb_acc;
	logic result_read;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cnv_sync_r <= 3'h7;
			fast_sync_r <= 2'h0;
			power_sync_r <= 2'h0;
			cs_sync_r <= 2'h3;
			req_sync_r <= 2'h3;
		end else begin
			cnv_sync_r <= {cnv_sync_r[1:0], i_convert_start_n};
			fast_sync_r <= {fast_sync_r[0], i_fast_sel};
			power_sync_r <= {power_sync_r[0], i_power_sel};
			cs_sync_r <= {cs_sync_r[0], i_cs_n};
			req_sync_r <= {req_sync_r[0], i_bus_req_n};
		end
	end

	// falling strobe, seen past the two synchronising stages
	assign cnv_fall = cnv_sync_r[2] && !cnv_sync_r[1];

	// ************************************************************
	// conversion sequencer
	// ************************************************************
	// a strobe arriving while busy is ignored: the converter cannot restart
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st_r <= ST_RST;
			cnt_r <= 8'h00;
			busy_r <= 1'b1;
			mode_r <= ADCRD_NORMAL;
			res_upd_r <= 1'b0;
			ser_run_r <= 1'b0;
			result_r <= 16'h0000;
		end else begin
			res_upd_r <= 1'b0;
			case (st_r)
				ST_RST: begin
					cnt_r <= cnt_r + 8'h01;
					if (cnt_r == RST_BUSY_CYC - 8'h01) begin
						busy_r <= 1'b0;
						st_r <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (cnv_fall) begin
						// mode sampled per conversion
						mode_r <= adcrd_mode_t'({power_sync_r[1], fast_sync_r[1]});
						busy_r <= 1'b1;
						cnt_r <= 8'h00;
						st_r <= ST_CONV;
					end
				end
				ST_CONV: begin
					cnt_r <= cnt_r + 8'h01;
					// result latched one cycle before busy falls when CTRL_SER_EN is clear
					if (cnt_r == conv_cyc(mode_r) - 8'h02) begin
						result_r <= i_conv_code;
						res_upd_r <= 1'b1;
						if (ctrl_r[CTRL_SER_EN]) begin
							ser_run_r <= 1'b1;
							st_r <= ST_SER;
						end else begin
							st_r <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					busy_r <= 1'b0;
					st_r <= ST_IDLE;
				end
				ST_SER: begin
					if (ser_if.done) begin
						busy_r <= 1'b0;
						ser_run_r <= 1'b0;
						st_r <= ST_IDLE;
					end
				end
				default: begin
					st_r <= ST_IDLE;
					busy_r <= 1'b0;
				end
			endcase
		end
	end

	// start pulse rides on the latch cycle so sync follows at once
	assign ser_if.start = res_upd_r && ser_run_r;
	assign ser_if.word = result_r;
	assign ser_if.div = ctrl_r[CTRL_DIV_LSB +: 2];

	adcrd_ser u_ser (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.ser(ser_if.ser)
	);

	// ************************************************************
	// pin drivers
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			data_oe_n_r <= 1'b1;
			ser_oe_n_r <= 1'b1;
		end else begin
			data_oe_n_r <= cs_sync_r[1] || req_sync_r[1];
			ser_oe_n_r <= cs_sync_r[1];
		end
	end

	assign o_busy = busy_r;
	assign o_data = result_r;
	assign o_data_oe_n = data_oe_n_r;
	assign o_frame_sync = ser_if.sync;
	assign o_serial_clk = ser_if.sclk;
	assign o_serial_data_out = ser_if.sdo;
	assign o_frame_sync_oe_n = ser_oe_n_r;
	assign o_serial_clk_oe_n = ser_oe_n_r;
	assign o_serial_data_out_oe_n = ser_oe_n_r;

	// ************************************************************
	// apb slave
	// ************************************************************
	// one wait-free access phase; read data is prepared in the setup cycle
	assign apb_acc = i_psel && i_penable && pready_r;
	assign result_read = apb_acc && !i_pwrite && i_paddr == REG_RESULT;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (i_psel && !i_penable) begin
			pready_r <= 1'b1;
			pslverr_r <= !(i_paddr == REG_CTRL || i_paddr == REG_STATUS ||
				i_paddr == REG_RESULT);
			case (i_paddr)
				REG_CTRL: prdata_r <= {29'h0000_0000, ctrl_r};
				REG_STATUS: prdata_r <= {28'h000_0000, mode_r, valid_r, busy_r};
				REG_RESULT: prdata_r <= {16'h0000, result_r};
				default: prdata_r <= 32'h0000_0000;
			endcase
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ctrl_r <= CTRL_RESET;
		end else if (apb_acc && i_pwrite && i_paddr == REG_CTRL) begin
			ctrl_r <= i_pwdata[2:0];
		end
	end

	// a fresh result wins over a read that clears the flag
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			valid_r <= 1'b0;
		end else if (res_upd_r) begin
			valid_r <= 1'b1;
		end else if (result_read) begin
			valid_r <= 1'b0;
		end
	end

	assign o_prdata = prdata_r;
	assign o_pready = pready_r;
	assign o_pslverr = pslverr_r;

	// ************************************************************
	// checks
	// ************************************************************
	logic [7:0] busy_cnt_r;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !busy_r) begin
			busy_cnt_r <= 8'h00;
		end else if (busy_cnt_r != 8'hFF) begin
			busy_cnt_r <= busy_cnt_r + 8'h01;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_conv_latch;
		res_upd_r && !ser_run_r;
	endsequence
	sequence s_busy_drop;
		!busy_r && $past(busy_r);
	endsequence

	busy_rise_a: assert property (st_r == ST_IDLE && cnv_fall |=> busy_r)
		else $error("busy did not rise after convert strobe");
	conv_len_a: assert property ($fell(busy_r) && $past(st_r) == ST_DONE
		|-> $past(busy_cnt_r) == conv_cyc(mode_r) - 8'h01)
		else $error("parallel busy width differs from conversion time");
	data_first_a: assert property (s_conv_latch |=> s_busy_drop)
		else $error("busy did not fall one cycle after result latch");
	reset_busy_a: assert property ($fell(busy_r) && $past(st_r) == ST_RST
		|-> $past(cnt_r) == RST_BUSY_CYC - 8'h01)
		else $error("reset busy width wrong");
	bus_drive_a: assert property (!cs_sync_r[1] && !req_sync_r[1] |=> !o_data_oe_n)
		else $error("parallel bus not driven on request");
	bus_release_a: assert property (req_sync_r[1] |=> o_data_oe_n)
		else $error("parallel bus not released");
	ser_float_a: assert property (cs_sync_r[1] |=> o_serial_clk_oe_n && o_frame_sync_oe_n)
		else $error("serial pins driven while chip select high");
	sync_start_a: assert property (res_upd_r && ser_run_r |=> o_frame_sync)
		else $error("frame sync not raised after conversion");
	busy_after_sync_a: assert property (ser_run_r && $fell(o_frame_sync) |=> !busy_r)
		else $error("busy did not follow frame sync down");

endmodule : adcrd_top

// [inc/adcrd_pkg.sv]
// constants, types and helpers shared by the converter readout block
// assumes a single 20 MHz system clock; all times are in ns
package adcrd_pkg;

	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int CLK_NS = 50;
	localparam int T_BUSY_RISE_NS = 23;
	localparam int T_CONV_FAST_NS = 283;
	localparam int T_CONV_NORMAL_NS = 430;
	localparam int T_CONV_SCALED_NS = 560;
	localparam int T_RST_BUSY_NS = 600;
	localparam int T_BUS_DRIVE_NS = 20;
	localparam int T_SCLK_MAX0_NS = 12;
	localparam int T_SCLK_MAX1_NS = 25;
	localparam int T_SCLK_MAX2_NS = 50;
	localparam int T_SCLK_MAX3_NS = 100;

	// longest time rounded down to whole cycles, never below one
	function automatic int cyc_floor(input int t_ns);
		cyc_floor = (t_ns / CLK_NS < 1) ? 1 : t_ns / CLK_NS;
	endfunction : cyc_floor

	localparam logic [7:0] BUSY_RISE_CYC = 8'(cyc_floor(T_BUSY_RISE_NS));
	localparam logic [7:0] CONV_CYC_FAST = 8'(cyc_floor(T_CONV_FAST_NS));
	localparam logic [7:0] CONV_CYC_NORMAL = 8'(cyc_floor(T_CONV_NORMAL_NS));
	localparam logic [7:0] CONV_CYC_SCALED = 8'(cyc_floor(T_CONV_SCALED_NS));
	localparam logic [7:0] RST_BUSY_CYC = 8'(cyc_floor(T_RST_BUSY_NS));
	localparam logic [7:0] BUS_DRIVE_CYC = 8'(cyc_floor(T_BUS_DRIVE_NS));

	// ************************************************************
	// modes, states, registers
	// ************************************************************
	typedef enum logic [1:0] {
		ADCRD_NORMAL = 2'h0,
		ADCRD_FAST = 2'h1,
		ADCRD_SCALED = 2'h2,
		ADCRD_WIDE = 2'h3
	} adcrd_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CONV = 3'h1,
		ST_SER = 3'h3,
		ST_DONE = 3'h2,
		ST_RST = 3'h6
	} adcrd_state_t;

	localparam int RESULT_W = 16;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RESULT = 8'h08;
	localparam int CTRL_SER_EN = 0;
	localparam int CTRL_DIV_LSB = 1;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam int STAT_BUSY = 0;
	localparam int STAT_VALID = 1;
	localparam int STAT_MODE_LSB = 2;

	// wideband fast shares every figure of fast mode
	function automatic logic [7:0] conv_cyc(input adcrd_mode_t m);
		case (m)
			ADCRD_FAST, ADCRD_WIDE: conv_cyc = CONV_CYC_FAST;
			ADCRD_SCALED: conv_cyc = CONV_CYC_SCALED;
			default: conv_cyc = CONV_CYC_NORMAL;
		endcase
	endfunction : conv_cyc

	// half period of the serial clock, from its longest period
	function automatic logic [7:0] sclk_half(input logic [1:0] div);
		case (div)
			2'h0: sclk_half = 8'(cyc_floor(T_SCLK_MAX0_NS / 2));
			2'h1: sclk_half = 8'(cyc_floor(T_SCLK_MAX1_NS / 2));
			2'h2: sclk_half = 8'(cyc_floor(T_SCLK_MAX2_NS / 2));
			default: sclk_half = 8'(cyc_floor(T_SCLK_MAX3_NS / 2));
		endcase
	endfunction : sclk_half

endpackage : adcrd_pkg

// [inc/adcrd_ser_if.sv]
// link between the conversion sequencer and the master serial shifter
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface adcrd_ser_if;
	logic start;
	logic [15:0] word;
	logic [1:0] div;
	logic done;
	logic sync;
	logic sclk;
	logic sdo;
	modport ctl (output start, word, div, input done, sync, sclk, sdo);
	modport ser (input start, word, div, output done, sync, sclk, sdo);
endinterface : adcrd_ser_if

// [hw/adcrd_ser.sv]
// master serial shifter: frame sync, internal serial clock, data msb first
// assumes the sequencer pulses start only while the shifter is idle
`timescale 1ns/1ps
module adcrd_ser
	import adcrd_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	adcrd_ser_if.ser ser
);

	logic active_r;
	logic [7:0] hcnt_r;
	logic [7:0] half_r;
	logic [4:0] bits_r;
	logic [15:0] sh_r;

	// ************************************************************
	// shifter
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			active_r <= 1'b0;
			hcnt_r <= 8'h00;
			half_r <= 8'h01;
			bits_r <= 5'h00;
			sh_r <= 16'h0000;
			ser.sync <= 1'b0;
			ser.sclk <= 1'b0;
			ser.sdo <= 1'b0;
			ser.done <= 1'b0;
		end else begin
			ser.done <= 1'b0;
			if (ser.start) begin
				// sync leads the first clock edge by a whole half period
				active_r <= 1'b1;
				half_r <= sclk_half(ser.div);
				hcnt_r <= sclk_half(ser.div) - 8'h01;
				bits_r <= 5'h10;
				sh_r <= ser.word;
				ser.sync <= 1'b1;
				ser.sclk <= 1'b0;
				ser.sdo <= ser.word[15];
			end else if (active_r) begin
				if (hcnt_r != 8'h00) begin
					hcnt_r <= hcnt_r - 8'h01;
				end else begin
					hcnt_r <= half_r - 8'h01;
					if (!ser.sclk) begin
						ser.sclk <= 1'b1;
					end else begin
						ser.sclk <= 1'b0;
						if (bits_r == 5'h01) begin
							// sync drops on the last falling edge, not before
							ser.sync <= 1'b0;
							active_r <= 1'b0;
							ser.done <= 1'b1;
						end else begin
							sh_r <= {sh_r[14:0], 1'b0};
							ser.sdo <= sh_r[14];
							bits_r <= bits_r - 5'h01;
						end
					end
				end
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sync_lead_a: assert property ($rose(ser.sclk) |-> $past(ser.sync))
		else $error("serial clock edge without frame sync ahead");
	// every divider lands on a one-cycle half period at this clock rate
	sclk_width_a: assert property ($rose(ser.sclk) |=> !ser.sclk)
		else $error("serial clock high longer than half period");
	sclk_low_a: assert property ($fell(ser.sclk) && ser.sync |=> ser.sclk)
		else $error("serial clock low longer than half period");

endmodule : adcrd_ser

// [verification/adcrd_host.sv]
// host controller model: issues convert strobes and supplies comparator codes
// assumes the bench pulses i_go for one cycle and watches busy itself
`timescale 1ns/1ps
module adcrd_host (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_go,
	input wire logic i_busy,
	output logic o_convert_start_n,
	output logic [15:0] o_conv_code
);
	logic [4:0] gap_r;
	// ************************************************************
	// strobe spacing
	// ************************************************************
	// 17 idle cycles cover 800 ns spacing and the acquisition window
	// restarts wait out the 17-cycle gap and a low i_busy before the next strobe
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_convert_start_n <= 1'b1;
			gap_r <= 5'h00;
			o_conv_code <= 16'hC35A;
		end else if (!o_convert_start_n) begin
			o_convert_start_n <= 1'b1;
		end else if (gap_r != 5'h00) begin
			gap_r <= gap_r - 5'h01;
		end else if (i_go && !i_busy) begin
			o_convert_start_n <= 1'b0;
			gap_r <= 5'h11;
			o_conv_code <= o_conv_code + 16'h3A97;
		end
	end
endmodule : adcrd_host

// [verification/tb_top.sv]
// self-checking bench for the converter sequencer and readout
// assumes the host model drives the strobe and code; apb and pins from here
`timescale 1ns/1ps
module tb_top
	import adcrd_pkg::*;
;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic fast = 0, pwr = 0, cs_n = 0, req_n = 1, go = 0, cvs_n, busy, er;
	logic [15:0] code, data;
	logic data_oe_n, fs, fs_oe_n, sclk, sclk_oe_n, sdo, sdo_oe_n;
	int mismatches = 0, num_checks = 0;
	always #25 clk = ~clk;
	adcrd_host HOST (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_busy(busy),
		.o_convert_start_n(cvs_n), .o_conv_code(code));
	adcrd_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_convert_start_n(cvs_n),
		.i_fast_sel(fast), .i_power_sel(pwr), .i_cs_n(cs_n), .i_bus_req_n(req_n),
		.i_conv_code(code), .o_busy(busy), .o_data(data), .o_data_oe_n(data_oe_n),
		.o_frame_sync(fs), .o_frame_sync_oe_n(fs_oe_n), .o_serial_clk(sclk),
		.o_serial_clk_oe_n(sclk_oe_n), .o_serial_data_out(sdo),
		.o_serial_data_out_oe_n(sdo_oe_n));
	// ************************************************************
	// shared tasks
	// ************************************************************
	task stop_test;
		if (mismatches == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask : chk
	// apb master: hold the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// no wait count assumed: only the watchdog ends a stuck access
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic start(input logic [1:0] md, output logic [15:0] exp);
		int k;
		@(posedge clk);
		{pwr, fast} <= md;
		repeat (4) @(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (busy !== 1'b1 && k < 20);
		exp = code;
		chk("busy_rise", 1, k <= 4);
	endtask : start
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic par_conv(input logic [1:0] md, input int n);
		int k;
		logic [15:0] exp, last;
		start(md, exp);
		k = 1;
		last = data;
		while (k < 40) begin
			@(posedge clk);
			#1;
			if (busy !== 1'b1)
				break;
			k++;
			last = data;
		end
		chk("busy_width", n, k);
		chk("data_before_fall", exp, last);
		chk("data_after_fall", exp, data);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", {28'h0, md, 2'h2}, rd & 32'hF);
		apb(1'b0, REG_RESULT, 32'h0);
		chk("result_reg", {16'h0, exp}, rd);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("valid_cleared", 0, rd[STAT_VALID]);
	endtask : par_conv
	task automatic ser_conv(input logic [1:0] md, input int lim);
		int k, nb, kf;
		logic [15:0] exp, sh;
		logic ps, pk;
		start(md, exp);
		k = 1;
		nb = 0;
		kf = 0;
		ps = 0;
		pk = 0;
		sh = 16'h0;
		while (k < 80) begin
			@(posedge clk);
			#1;
			if (busy !== 1'b1)
				break;
			k++;
			if (fs === 1'b1 && ps !== 1'b1)
				chk("sclk_at_sync", 0, sclk);
			if (fs === 1'b1 && sclk === 1'b1 && pk !== 1'b1) begin
				sh = {sh[14:0], sdo};
				nb++;
			end
			if (fs !== 1'b1 && ps === 1'b1)
				kf = k;
			ps = fs;
			pk = sclk;
		end
		chk("sclk_rises", 16, nb);
		chk("serial_word", {16'h0, exp}, {16'h0, sh});
		chk("busy_after_sync", kf, k);
		chk("serial_busy_width", 1, k <= lim);
	endtask : ser_conv
	task automatic pins;
		@(posedge clk);
		cs_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("float_cs_high", 3'h7, {fs_oe_n, sclk_oe_n, sdo_oe_n});
		chk("bus_cs_high", 1, data_oe_n);
		@(posedge clk);
		cs_n <= 1'b0;
		req_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("drive_cs_low", 3'h0, {fs_oe_n, sclk_oe_n, sdo_oe_n});
		chk("bus_drive", 0, data_oe_n);
		@(posedge clk);
		req_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("bus_release", 1, data_oe_n);
	endtask : pins
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		int k;
		repeat (5) @(posedge clk);
		chk("busy_in_reset", 1, busy);
		rst_n <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (busy === 1'b1 && k < 30);
		chk("reset_busy", 1, k >= 11 && k <= 13);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl_reset", 0, rd);
		apb(1'b1, REG_CTRL, 32'h6);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl_rw", 32'h6, rd);
		apb(1'b1, 8'h0C, 32'hFFFF);
		chk("unmapped_err", 1, er);
		apb(1'b0, 8'h0C, 32'h0);
		chk("unmapped_rd", 0, {rd[30:0], er} ^ 32'h1);
		par_conv(2'h0, 32'(CONV_CYC_NORMAL));
		par_conv(2'h1, 32'(CONV_CYC_FAST));
		par_conv(2'h2, 32'(CONV_CYC_SCALED));
		par_conv(2'h3, 32'(CONV_CYC_FAST));
		pins();
		apb(1'b1, REG_CTRL, 32'h7);
		ser_conv(2'h1, 2040 / CLK_NS);
		ser_conv(2'h3, 2040 / CLK_NS);
		ser_conv(2'h0, 2190 / CLK_NS);
		ser_conv(2'h2, 2320 / CLK_NS);
		stop_test();
	end
	// watchdog: the sequence needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		stop_test();
	end
endmodule : tb_top
